//--- verilog/lcs_pkg.sv
// package: register map, field layout and reset values of the logic cell input stage
package lcs_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned NUM_MUX = 4;
   localparam int unsigned NUM_GATE = 4;
   localparam int unsigned CODE_W = 3;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_SOURCE_SELECT = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_GATE_ENABLE = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_GATE_POLARITY = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_LIVE_STATUS = 12'h00C;
   // selector field positions in the source select register
   localparam int unsigned MUX1_LSB = 0;
   localparam int unsigned MUX2_LSB = 4;
   localparam int unsigned MUX3_LSB = 8;
   localparam int unsigned MUX4_LSB = 12;
   localparam logic [DATA_W-1:0] SEL_IMPL_MASK = 32'h0000_7777;
   localparam logic [DATA_W-1:0] GATE_IMPL_MASK = 32'hFFFF_FFFF;
   localparam logic [DATA_W-1:0] POL_IMPL_MASK = 32'h0000_000F;
   // bits per gate byte in the gate enable register
   localparam int unsigned GATE_BYTE_W = 8;
   // live status layout: mux outputs low nibble, gate outputs next nibble
   localparam int unsigned STAT_MUX_LSB = 0;
   localparam int unsigned STAT_GATE_LSB = 4;
   // reset values
   localparam logic [DATA_W-1:0] SEL_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] GATE_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] POL_RESET = 32'h0000_0000;
   // selector codes
   localparam logic [CODE_W-1:0] CODE0 = 3'h0;
   localparam logic [CODE_W-1:0] CODE1 = 3'h1;
   localparam logic [CODE_W-1:0] CODE2 = 3'h2;
   localparam logic [CODE_W-1:0] CODE3 = 3'h3;
   localparam logic [CODE_W-1:0] CODE4 = 3'h4;
   localparam logic [CODE_W-1:0] CODE5 = 3'h5;
   localparam logic [CODE_W-1:0] CODE6 = 3'h6;
   localparam logic [CODE_W-1:0] CODE7 = 3'h7;
endpackage

//--- verilog/lcs_input_stage.sv
// logic cell input stage: four source multiplexers, four input gates, APB registers
// Operation
// (RULE1) mux 4 selector sits in source select bits 14 to 12
// (RULE2) mux 4: 000 pin b, 101 real-time clock event, 100 third comparator
// (RULE3) mux 4: 110 and 111 compare-match events, 010 single-output unit output
// (RULE4) mux 4: 001 paired neighbour cell, 011 serial data in, reserved on cell 4
// (RULE5) mux 3 selector in bits 10 to 8; 000 pin a, 001 own cell output
// (RULE6) mux 3: 010 comparator 2, 011 serial out, 100 uart rx, 101, 110, 111
// (RULE7) mux 2 selector in bits 6 to 4; 000 pin b, 001 neighbour, 010 comparator 1
// (RULE8) mux 2: 011 uart tx, 100 converter done, 101 dma, 110 match, 111 unused
// (RULE9) mux 2 code 101 takes dma channel 0 on cells 1, 3, else channel 1
// (RULE10) mux 1 selector in bits 2 to 0; pin a, system, secondary, low-power clocks
// (RULE11) mux 1: 100 reference clock, 101 to 111 three multi-output unit outputs
// (RULE12) source select bits 31 to 15, 11, 7, 3 ignore writes, read zero
// (RULE13) source select bit 7 reads zero between mux 3 and mux 2 fields
// (RULE14) gate enable holds one byte per gate, gate 4 in bits 31 to 24
// (RULE15) each byte pairs true then negated enables, source 4 down to source 1
// (RULE16) a set true enable feeds the plain mux output into its gate
// (RULE17) a set negated enable feeds the complemented mux output into its gate
// (RULE18) clearing a true enable affects only that gate, not other gates
// (RULE19) each gate ors all its enabled true and complemented sources
// (RULE20) a gate with nothing enabled gives a constant set by its polarity
// (RULE21) polarity bit set inverts the gate output, clear passes it unchanged
// (RULE22) unused or reserved selector codes drive constant zero
// (RULE23) selectors and enables reset to zero and are software read/write
`timescale 1ns/1ns
`default_nettype none
module lcs_input_stage #(
   parameter int unsigned CELL_INDEX = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [lcs_pkg::ADDR_W-1:0] paddr,
   input wire logic [lcs_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic pslverr,
   output logic [lcs_pkg::DATA_W-1:0] prdata,
   input wire logic cell_input_pin_a,
   input wire logic cell_input_pin_b,
   input wire logic own_cell_out,
   input wire logic neighbour_cell_out,
   input wire logic sys_clock_src,
   input wire logic secondary_oscillator_clock,
   input wire logic low_power_rc_clock,
   input wire logic reference_clock_output,
   input wire logic [2:0] multi_output_capture_compare,
   input wire logic single_output_capture_compare_m3,
   input wire logic single_output_capture_compare_m4,
   input wire logic compare_match_event_m2,
   input wire logic [1:0] compare_match_event_m3,
   input wire logic [1:0] compare_match_event_m4,
   input wire logic first_comparator_output,
   input wire logic second_comparator_output,
   input wire logic third_comparator_output,
   input wire logic real_time_clock_event,
   input wire logic serial_data_in,
   input wire logic serial_data_out,
   input wire logic uart_rx_in,
   input wire logic uart_tx_out,
   input wire logic converter_done_event,
   input wire logic dma_ch0_irq,
   input wire logic dma_ch1_irq,
   output logic [lcs_pkg::NUM_MUX-1:0] mux_out,
   output logic [lcs_pkg::NUM_GATE-1:0] gate_out
);
   import lcs_pkg::*;

   logic [DATA_W-1:0] source_select_ff;
   logic [DATA_W-1:0] gate_input_enable_ff;
   logic [DATA_W-1:0] gate_polarity_invert_ff;
   logic [DATA_W-1:0] nxt_source_select;
   logic [DATA_W-1:0] nxt_gate_input_enable;
   logic [DATA_W-1:0] nxt_gate_polarity_invert;
   logic [DATA_W-1:0] prdata_ff;
   logic [DATA_W-1:0] nxt_prdata;

   // per-cell wiring choices
   localparam bit IS_CELL4 = (CELL_INDEX == 4);
   localparam bit ODD_CELL = (CELL_INDEX % 2) == 1;

   // apb decode
   wire access = psel & penable;
   wire hit_sel = (paddr == OFS_SOURCE_SELECT);
   wire hit_gate = (paddr == OFS_GATE_ENABLE);
   wire hit_pol = (paddr == OFS_GATE_POLARITY);
   wire hit_stat = (paddr == OFS_LIVE_STATUS);
   wire hit_any = hit_sel | hit_gate | hit_pol | hit_stat;
   wire wr_sel = access & pwrite & hit_sel;
   wire wr_gate = access & pwrite & hit_gate;
   wire wr_pol = access & pwrite & hit_pol;

   // byte-lane write mask from pstrb
   wire [DATA_W-1:0] lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

   // selector fields
   wire [CODE_W-1:0] mux1_source_code = source_select_ff[MUX1_LSB +: CODE_W]; // RULE10
   wire [CODE_W-1:0] mux2_source_code = source_select_ff[MUX2_LSB +: CODE_W]; // RULE7
   wire [CODE_W-1:0] mux3_source_code = source_select_ff[MUX3_LSB +: CODE_W]; // RULE5
   wire [CODE_W-1:0] mux4_source_code = source_select_ff[MUX4_LSB +: CODE_W]; // RULE1

   // candidate vectors, index equals selector code
   wire [7:0] cand1;
   wire [7:0] cand2;
   wire [7:0] cand3;
   wire [7:0] cand4;
   wire dma_pick = ODD_CELL ? dma_ch0_irq : dma_ch1_irq; // RULE9

   // mux 1: pin, clocks, reference clock, multi-output unit
   assign cand1 = {multi_output_capture_compare[2], multi_output_capture_compare[1],
                   multi_output_capture_compare[0], reference_clock_output, // RULE11
                   low_power_rc_clock, secondary_oscillator_clock,
                   sys_clock_src, cell_input_pin_a}; // RULE10
   // mux 2: 111 drives zero
   assign cand2 = {1'b0, compare_match_event_m2, dma_pick, converter_done_event, // RULE22 RULE8
                   uart_tx_out & ~IS_CELL4, first_comparator_output,
                   neighbour_cell_out, cell_input_pin_b}; // RULE7
   // mux 3: cell 4 reserves 011 and 100
   assign cand3 = {compare_match_event_m3[1], compare_match_event_m3[0],
                   single_output_capture_compare_m3, uart_rx_in & ~IS_CELL4, // RULE6 RULE22
                   serial_data_out & ~IS_CELL4, second_comparator_output,
                   own_cell_out, cell_input_pin_a}; // RULE5
   // mux 4: cell 4 reserves 011
   assign cand4 = {compare_match_event_m4[1], compare_match_event_m4[0], // RULE3
                   real_time_clock_event, third_comparator_output, // RULE2
                   serial_data_in & ~IS_CELL4, single_output_capture_compare_m4, // RULE4 RULE22
                   neighbour_cell_out, cell_input_pin_b}; // RULE2 RULE4

   // mux outputs
   assign mux_out[0] = cand1[mux1_source_code];
   assign mux_out[1] = cand2[mux2_source_code];
   assign mux_out[2] = cand3[mux3_source_code];
   assign mux_out[3] = cand4[mux4_source_code];

   // input gates, one byte of enables each
   genvar g;
   genvar s;
   generate
      for (g = 0; g < NUM_GATE; g++) begin : gen_gate
         wire [GATE_BYTE_W-1:0] en_byte = gate_input_enable_ff[g*GATE_BYTE_W +: GATE_BYTE_W]; // RULE14
         wire [NUM_MUX-1:0] gate_source_true_enable;
         wire [NUM_MUX-1:0] gate_source_negated_enable;
         wire [NUM_MUX-1:0] term;
         for (s = 0; s < NUM_MUX; s++) begin : gen_src
            // source s+1: true at bit 2s+1, negated at bit 2s
            assign gate_source_true_enable[s] = en_byte[2*s+1]; // RULE15
            assign gate_source_negated_enable[s] = en_byte[2*s]; // RULE15
            assign term[s] = (mux_out[s] & gate_source_true_enable[s]) | // RULE16 RULE18
                             (~mux_out[s] & gate_source_negated_enable[s]); // RULE17
         end
         // or then polarity; empty gate yields polarity bit
         assign gate_out[g] = (|term) ^ gate_polarity_invert_ff[g]; // RULE19 RULE20 RULE21
      end
   endgenerate

   // next register values; unimplemented bits never stored
   assign nxt_source_select = wr_sel ?
      ((source_select_ff & ~lane_mask) | (pwdata & lane_mask)) & SEL_IMPL_MASK : // RULE12 RULE13
      source_select_ff;
   assign nxt_gate_input_enable = wr_gate ?
      ((gate_input_enable_ff & ~lane_mask) | (pwdata & lane_mask)) & GATE_IMPL_MASK :
      gate_input_enable_ff;
   assign nxt_gate_polarity_invert = wr_pol ?
      ((gate_polarity_invert_ff & ~lane_mask) | (pwdata & lane_mask)) & POL_IMPL_MASK :
      gate_polarity_invert_ff;

   // register storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         source_select_ff <= SEL_RESET; // RULE23
         gate_input_enable_ff <= GATE_RESET; // RULE23
         gate_polarity_invert_ff <= POL_RESET;
      end else begin
         source_select_ff <= nxt_source_select;
         gate_input_enable_ff <= nxt_gate_input_enable;
         gate_polarity_invert_ff <= nxt_gate_polarity_invert;
      end
   end

   // live status word
   wire [DATA_W-1:0] live_status = {24'h00_0000, gate_out, mux_out};

   // answer at once, error on an unmapped access
   assign pready = 1'b1;
   assign pslverr = access & ~hit_any;

   // read word picked by address; live status is taken in the setup cycle
   wire rd_setup = psel & ~penable & ~pwrite;
   wire [DATA_W-1:0] read_word = hit_sel ? source_select_ff : // RULE23
                                 hit_gate ? gate_input_enable_ff :
                                 hit_pol ? gate_polarity_invert_ff :
                                 hit_stat ? live_status : 32'h0000_0000;
   // captured at the setup edge so it stands through the access phase, zero otherwise
   assign nxt_prdata = rd_setup ? read_word : 32'h0000_0000;

   // read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else begin
         prdata_ff <= nxt_prdata;
      end
   end
   assign prdata = prdata_ff;
endmodule
`default_nettype wire

//--- verification/lcs_input_stage_properties.sv
// checker: selector routing, read masks, error reply and reset state
`timescale 1ns/1ns
`default_nettype none
module lcs_input_stage_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [lcs_pkg::ADDR_W-1:0] paddr,
   input wire logic [lcs_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pslverr,
   input wire logic [lcs_pkg::DATA_W-1:0] prdata,
   input wire logic own_cell_out,
   input wire logic sys_clock_src,
   input wire logic first_comparator_output,
   input wire logic real_time_clock_event,
   input wire logic [lcs_pkg::NUM_MUX-1:0] mux_out,
   input wire logic [lcs_pkg::NUM_GATE-1:0] gate_out
);
   import lcs_pkg::*;
   logic [15:0] sel_ff;
   logic [15:0] lane;
   logic rd_sel;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign lane = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   assign rd_sel = psel && penable && !pwrite && paddr == OFS_SOURCE_SELECT;
   // shadow of the selector fields, lane by lane
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sel_ff <= 16'h0000;
      else if (psel && penable && pwrite && paddr == OFS_SOURCE_SELECT)
         sel_ff <= (lane & pwdata[15:0] | ~lane & sel_ff) & 16'h7777;
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_bad_access;
      psel && penable && paddr[11:4] != 8'h00;
   endsequence
   AST_BAD_ADDR: assert property (s_setup ##1 s_bad_access |-> pslverr && prdata == '0) else $error("bad address");
   AST_SEL_MASK: assert property (rd_sel |-> prdata[31:15] == '0) else $error("select high bits");
   AST_SEL_GAPS: assert property (rd_sel |-> !prdata[7] && !prdata[3] && !prdata[11]) else $error("gap");
   AST_SEL_BACK: assert property (rd_sel |-> prdata[15:0] == sel_ff) else $error("select readback");
   AST_MUX1_SYS: assert property (sel_ff[2:0] == CODE1 |-> mux_out[0] == sys_clock_src) else $error("mux1");
   AST_MUX2_CMP: assert property (sel_ff[6:4] == CODE2 |-> mux_out[1] == first_comparator_output) else $error("m2");
   AST_MUX2_NIL: assert property (sel_ff[6:4] == CODE7 |-> !mux_out[1]) else $error("mux2 unused");
   AST_MUX3_OWN: assert property (sel_ff[10:8] == CODE1 |-> mux_out[2] == own_cell_out) else $error("mux3");
   AST_MUX4_RTC: assert property (sel_ff[14:12] == CODE5 |-> mux_out[3] == real_time_clock_event) else $error("m4");
   AST_RST_GATE: assert property ($rose(presetn) |-> gate_out == '0) else $error("gates after reset");
endmodule
bind lcs_input_stage lcs_input_stage_properties i_lcs_input_stage_properties (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .pslverr, .prdata, .own_cell_out, .sys_clock_src, .first_comparator_output,
   .real_time_clock_event, .mux_out, .gate_out);
`default_nettype wire

//--- verification/lcs_src_model.sv
// source model: peripheral, clock and pin levels feeding the muxes
`timescale 1ns/1ns
`default_nettype none
module lcs_src_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [28:0] nxt_src,
   output logic [28:0] src_ff
);
   // levels move only just after a clock edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) src_ff <= '0;
      else src_ff <= nxt_src;
   end
endmodule
`default_nettype wire

//--- verification/testbench.sv
// testbench: apb register checks and random routing against a reference model
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import lcs_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd, d, lm;
   logic [DATA_W-1:0] m[4];
   logic [DATA_W-1:0] msk[4] = '{32'h7777, 32'hFFFF_FFFF, 32'hF, 32'h0};
   logic [3:0] pstrb, st, mux_out, gate_out, mux_odd, gate_odd;
   logic [28:0] s, nxt_src;
   logic [29:0] sz;
   int fail_count, n_compared, seed;
   int tbl[4][8] = '{'{0, 4, 5, 6, 7, 8, 9, 10}, '{1, 3, 18, 29, 26, 28, 13, 29}, '{0, 2, 19, 29, 29, 11, 14, 15},
      '{1, 3, 12, 29, 20, 21, 16, 17}};
   // odd cell: no reserved codes, dma channel 0 at mux 2 code 101
   int tbo[4][8] = '{'{0, 4, 5, 6, 7, 8, 9, 10}, '{1, 3, 18, 25, 26, 27, 13, 29}, '{0, 2, 19, 23, 24, 11, 14, 15},
      '{1, 3, 12, 22, 20, 21, 16, 17}};
   assign sz = {1'b0, s};
   lcs_src_model i_lcs_src_model (.pclk, .presetn, .nxt_src, .src_ff(s));
   lcs_input_stage #(.CELL_INDEX(4)) i_lcs_input_stage (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .pready, .pslverr, .prdata, .mux_out, .gate_out, .cell_input_pin_a(s[0]), .cell_input_pin_b(s[1]),
      .own_cell_out(s[2]), .neighbour_cell_out(s[3]), .sys_clock_src(s[4]), .secondary_oscillator_clock(s[5]),
      .low_power_rc_clock(s[6]), .reference_clock_output(s[7]), .multi_output_capture_compare(s[10:8]),
      .single_output_capture_compare_m3(s[11]), .single_output_capture_compare_m4(s[12]),
      .compare_match_event_m2(s[13]), .compare_match_event_m3(s[15:14]), .compare_match_event_m4(s[17:16]),
      .first_comparator_output(s[18]), .second_comparator_output(s[19]), .third_comparator_output(s[20]),
      .real_time_clock_event(s[21]), .serial_data_in(s[22]), .serial_data_out(s[23]), .uart_rx_in(s[24]),
      .uart_tx_out(s[25]), .converter_done_event(s[26]), .dma_ch0_irq(s[27]), .dma_ch1_irq(s[28]));
   // second cell on the same bus, odd index; only its routing outputs are watched
   lcs_input_stage #(.CELL_INDEX(1)) i_lcs_input_stage_odd (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .pready(), .pslverr(), .prdata(), .mux_out(mux_odd), .gate_out(gate_odd),
      .cell_input_pin_a(s[0]), .cell_input_pin_b(s[1]), .own_cell_out(s[2]), .neighbour_cell_out(s[3]),
      .sys_clock_src(s[4]), .secondary_oscillator_clock(s[5]), .low_power_rc_clock(s[6]),
      .reference_clock_output(s[7]), .multi_output_capture_compare(s[10:8]),
      .single_output_capture_compare_m3(s[11]), .single_output_capture_compare_m4(s[12]),
      .compare_match_event_m2(s[13]), .compare_match_event_m3(s[15:14]), .compare_match_event_m4(s[17:16]),
      .first_comparator_output(s[18]), .second_comparator_output(s[19]), .third_comparator_output(s[20]),
      .real_time_clock_event(s[21]), .serial_data_in(s[22]), .serial_data_out(s[23]), .uart_rx_in(s[24]),
      .uart_tx_out(s[25]), .converter_done_event(s[26]), .dma_ch0_irq(s[27]), .dma_ch1_irq(s[28]));
   // expected gates and muxes: or of enabled true/negated sources, then polarity
   function automatic logic [7:0] model(input bit odd);
      logic [3:0] mx, g;
      for (int k = 0; k < 4; k++) mx[k] = sz[odd ? tbo[k][m[0][4*k+:3]] : tbl[k][m[0][4*k+:3]]];
      g = '0;
      for (int k = 0; k < 32; k++) g[k/8] |= m[1][k] & (mx[(k%8)/2] ^ (k % 2 == 0));
      return {g ^ m[2][3:0], mx};
   endfunction
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] ws);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, wd, ws};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      {er, rd} = {pslverr, prdata};
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask
   task automatic rdchk(input int r);
      apb(1'b0, 12'(4 * r), 32'h0, 4'h0);
      chk({er, rd}, {1'b0, r == 3 ? {24'h0, model(1'b0)} : m[r]});
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      #100000;
      fail_count++;
      summarize();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb, nxt_src, presetn} = '0;
      {fail_count, n_compared, m[0], m[1], m[2], m[3]} = '0;
      seed = 32'he3657dcb;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // reset values, then an unmapped write and read
      for (int r = 0; r < 4; r++) rdchk(r);
      apb(1'b1, 12'h010, 32'hFFFF_FFFF, 4'hF);
      apb(1'b0, 12'h010, 32'h0, 4'h0);
      chk({er, rd}, {1'b1, 32'h0});
      $display("reset and address test done");
      // random selectors, enables, polarity and source levels
      for (int i = 0; i < 300; i++) begin
         nxt_src <= 29'($random(seed));
         for (int r = 0; r < 4; r++) begin
            d = $random(seed);
            st = 4'($random(seed));
            apb(1'b1, 12'(4 * r), d, st);
            lm = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
            m[r] = (m[r] & ~lm | d & lm) & msk[r];
            rdchk(r);
         end
         chk({25'h0, gate_out, mux_out}, {25'h0, model(1'b0)});
         chk({25'h0, gate_odd, mux_odd}, {25'h0, model(1'b1)});
      end
      $display("random routing test done");
      // reset in mid-run clears every register of both cells
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      {m[0], m[1], m[2], m[3]} = '0;
      @(posedge pclk);
      for (int r = 0; r < 4; r++) rdchk(r);
      chk({25'h0, gate_out, mux_out}, {25'h0, model(1'b0)});
      chk({25'h0, gate_odd, mux_odd}, {25'h0, model(1'b1)});
      $display("mid-run reset test done");
      summarize();
   end
endmodule
`default_nettype wire
